//--- inc/pol_sup_params.svh
`ifndef POL_SUP_PARAMS_SVH
`define POL_SUP_PARAMS_SVH

`define CORE_CLK_HZ        10000000
`define MV_W               16
`define VOUT_ABS_MAX_MV    16'd5500
`define VMAX_PCT           110
`define MARGIN_HI_PCT      105
`define MARGIN_LO_PCT      95
`define OV_PCT             115
`define UV_PCT             85
`define PG_ON_PCT          90
`define PG_OFF_PCT         85
`define STRAP_OPEN_CODE    16'hffff
`define STRAP_TRACK_MAX    16'd422
`define STRAP_TOP_BAND     16'd6500
`define FAULT_DELAY_US     10
`define FAULT_DELAY_CYC    ((`FAULT_DELAY_US * `CORE_CLK_HZ) / 1000000)
`define HICCUP_MS          10
`define HICCUP_CYC         ((`HICCUP_MS * `CORE_CLK_HZ) / 1000)
`define DLY_CNT_W          8
`define HIC_CNT_W          20
`define SRC_PIN_RST        2'h0
`define VRESP_RST          2'h3
`define OCRESP_RST         2'h2

`endif

//--- inc/pol_sup_pkg.sv
package pol_sup_pkg;
  typedef enum logic [1:0] {
    SRC_PIN,
    SRC_OPERATION,
    SRC_BOTH,
    SRC_ALWAYS
  } on_src_t;

  typedef enum logic [1:0] {
    VRESP_IGNORE,
    VRESP_DELAYED,
    VRESP_LATCH,
    VRESP_WHILE_PRESENT
  } vresp_t;

  typedef enum logic [1:0] {
    OCRESP_CONTINUE,
    OCRESP_LATCH,
    OCRESP_HICCUP,
    OCRESP_DELAYED
  } ocresp_t;

  typedef enum logic [1:0] {
    MARGIN_NONE,
    MARGIN_LOW,
    MARGIN_HIGH,
    MARGIN_RSVD
  } margin_t;
endpackage

//--- inc/strap_if.sv
`timescale 1ns/10ps
interface strap_if;
  logic [15:0] res;
  logic        sample;
  logic [15:0] setpoint_mv;
  logic        track;
  modport main (output res, output sample, input setpoint_mv, input track);
  modport dec  (input res, input sample, output setpoint_mv, output track);
endinterface

//--- hw/strap_decoder.sv
`timescale 1ns/10ps
`include "pol_sup_params.svh"
module strap_decoder
  import pol_sup_pkg::*;
(
  input  wire logic core_clk_i,
  input  wire logic reset_i,
  input  wire logic clk_en_i,
  strap_if.dec      strap
);

  typedef struct packed {
    logic [15:0] setpoint_mv;
    logic        track;
  } dec_state_t;

  dec_state_t st_r;
  dec_state_t st_nxt;

  // Resistance in 10 ohm units, bands split midway between nominal values
  function automatic logic [15:0] band_mv(input logic [15:0] r);
    if      (r < 16'd565)  band_mv = 16'd600;
    else if (r < 16'd667)  band_mv = 16'd700;
    else if (r < 16'd770)  band_mv = 16'd750;
    else if (r < 16'd889)  band_mv = 16'd800;
    else if (r < 16'd1026) band_mv = 16'd850;
    else if (r < 16'd1185) band_mv = 16'd900;
    else if (r < 16'd1370) band_mv = 16'd950;
    else if (r < 16'd1625) band_mv = 16'd1000;
    else if (r < 16'd1965) band_mv = 16'd1050;
    else if (r < 16'd2380) band_mv = 16'd1100;
    else if (r < 16'd2885) band_mv = 16'd1200;
    else if (r < 16'd3495) band_mv = 16'd1500;
    else if (r < 16'd4125) band_mv = 16'd1800;
    else if (r < 16'd4765) band_mv = 16'd2500;
    else if (r < 16'd5505) band_mv = 16'd3300;
    else                   band_mv = 16'd5000;
  endfunction

  always_comb begin
    st_nxt = st_r;
    if (strap.sample) begin
      if (strap.res == `STRAP_OPEN_CODE || strap.res > `STRAP_TOP_BAND) begin
        st_nxt.setpoint_mv = 16'h0000;
        st_nxt.track       = 1'b0;
      end else if (strap.res <= `STRAP_TRACK_MAX) begin
        st_nxt.setpoint_mv = 16'h0000;
        st_nxt.track       = 1'b1;
      end else begin
        st_nxt.setpoint_mv = band_mv(strap.res);
        st_nxt.track       = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      st_r <= '0;
    end else if (clk_en_i) begin
      st_r <= st_nxt;
    end
  end

  assign strap.setpoint_mv = st_r.setpoint_mv;
  assign strap.track       = st_r.track;

endmodule

//--- hw/output_enable_fault_supervisor.sv
`timescale 1ns/10ps
`include "pol_sup_params.svh"
module output_enable_fault_supervisor
  import pol_sup_pkg::*;
#(
  parameter int unsigned MV_W       = `MV_W,
  parameter int unsigned HICCUP_CYC = `HICCUP_CYC
) (
  input  wire logic              core_clk_i,
  input  wire logic              reset_i,
  input  wire logic              clk_en_i,
  input  wire logic              input_power_ok_i,
  input  wire logic              remote_on_off_i,
  input  wire logic [15:0]       setpoint_strap_resistor_i,
  input  wire logic [1:0]        on_off_source_i,
  input  wire logic              on_off_invert_i,
  input  wire logic              operation_on_i,
  input  wire logic [1:0]        margin_select_i,
  input  wire logic              vout_command_valid_i,
  input  wire logic [MV_W-1:0]   vout_command_i,
  input  wire logic [MV_W-1:0]   vout_trim_i,
  input  wire logic              margin_high_valid_i,
  input  wire logic [MV_W-1:0]   margin_high_i,
  input  wire logic              margin_low_valid_i,
  input  wire logic [MV_W-1:0]   margin_low_i,
  input  wire logic              vout_max_valid_i,
  input  wire logic [MV_W-1:0]   vout_max_i,
  input  wire logic              ov_limit_valid_i,
  input  wire logic [MV_W-1:0]   ov_limit_i,
  input  wire logic              uv_limit_valid_i,
  input  wire logic [MV_W-1:0]   uv_limit_i,
  input  wire logic              pg_on_valid_i,
  input  wire logic [MV_W-1:0]   pg_on_i,
  input  wire logic              pg_off_valid_i,
  input  wire logic [MV_W-1:0]   pg_off_i,
  input  wire logic [1:0]        ov_response_i,
  input  wire logic [1:0]        uv_response_i,
  input  wire logic [1:0]        oc_response_i,
  input  wire logic [15:0]       oc_limit_i,
  input  wire logic [MV_W-1:0]   vout_sense_i,
  input  wire logic [15:0]       iout_sense_i,
  input  wire logic              ramp_done_i,
  input  wire logic              calibration_done_i,
  input  wire logic              fault_clear_i,
  output logic                   output_enable_o,
  output logic [MV_W-1:0]        target_mv_o,
  output logic                   track_mode_o,
  output logic                   power_good_output_o,
  output logic                   power_good_output_oe_o,
  output logic                   over_voltage_fault_o,
  output logic                   under_voltage_fault_o,
  output logic                   over_current_fault_o,
  output logic                   oc_response_remapped_o
);

  typedef struct packed {
    logic                  pwr_q;
    logic                  req_q;
    logic                  ov_lat;
    logic                  uv_lat;
    logic                  oc_lat;
    logic [`DLY_CNT_W-1:0] ov_dly;
    logic [`DLY_CNT_W-1:0] uv_dly;
    logic [`HIC_CNT_W-1:0] hic_cnt;
    logic                  hic_act;
    logic                  en;
    logic [MV_W-1:0]       target;
    logic                  track;
    logic                  pg;
    logic                  ov_f;
    logic                  uv_f;
    logic                  oc_f;
    logic                  oc_remap;
  } sup_state_t;

  localparam logic [`DLY_CNT_W-1:0] DLY_LAST = `DLY_CNT_W'(`FAULT_DELAY_CYC - 1);
  localparam logic [`HIC_CNT_W-1:0] HIC_LAST = `HIC_CNT_W'(HICCUP_CYC - 1);

  sup_state_t st_r;
  sup_state_t st_nxt;

  strap_if strap ();

  strap_decoder u_strap (
    .core_clk_i (core_clk_i),
    .reset_i    (reset_i),
    .clk_en_i   (clk_en_i),
    .strap      (strap.dec)
  );

  function automatic logic [MV_W-1:0] pct_of(input logic [MV_W-1:0] v, input int unsigned pct);
    logic [31:0] p;
    p      = 32'(v) * 32'(pct) / 32'd100;
    pct_of = p[MV_W-1:0];
  endfunction

  function automatic logic [MV_W-1:0] pick(input logic use_ovr, input logic [MV_W-1:0] ovr,
                                           input logic [MV_W-1:0] dflt);
    pick = use_ovr ? ovr : dflt;
  endfunction

  // Shared response for both voltage faults; returns {shutdown, latch_next, count_next}
  function automatic logic [`DLY_CNT_W+1:0] vresp(input logic flt, input logic [1:0] resp,
                                                  input logic lat, input logic [`DLY_CNT_W-1:0] cnt,
                                                  input logic clr);
    logic                  sd;
    logic                  l;
    logic [`DLY_CNT_W-1:0] c;
    sd = 1'b0;
    l  = lat;
    c  = '0;
    case (vresp_t'(resp))
      VRESP_IGNORE: begin
        l = 1'b0;
      end
      VRESP_DELAYED: begin
        if (flt) begin
          if (cnt == DLY_LAST) begin
            c = cnt;
            l = 1'b1;
          end else begin
            c = cnt + 1'b1;
          end
        end
        if (clr && !(flt && cnt == DLY_LAST))
          l = 1'b0;
        sd = l;
      end
      VRESP_LATCH: begin
        if (clr)
          l = 1'b0;
        if (flt)
          l = 1'b1;
        sd = l;
      end
      VRESP_WHILE_PRESENT: begin
        l  = 1'b0;
        sd = flt;
      end
      default: begin
        l = 1'b0;
      end
    endcase
    vresp = {sd, l, c};
  endfunction

  logic            pin_on;
  logic            req;
  logic            req_rise;
  logic            clr;
  logic [MV_W-1:0] nominal;
  logic [MV_W-1:0] base;
  logic [MV_W-1:0] trimmed;
  logic [MV_W-1:0] vmax_dflt;
  logic [MV_W-1:0] vmax;
  logic [MV_W-1:0] ov_lim;
  logic [MV_W-1:0] uv_lim;
  logic [MV_W-1:0] pg_on_lim;
  logic [MV_W-1:0] pg_off_lim;
  logic            ov_now;
  logic            uv_now;
  logic            oc_now;
  logic [`DLY_CNT_W+1:0] ov_r;
  logic [`DLY_CNT_W+1:0] uv_r;
  ocresp_t         ocr;
  logic            oc_sd;
  logic            fault_sd;

  always_comb begin
    st_nxt = st_r;
    st_nxt.pwr_q = input_power_ok_i;
    pin_on = remote_on_off_i ^ on_off_invert_i;
    case (on_src_t'(on_off_source_i))
      SRC_PIN:       req = pin_on;
      SRC_OPERATION: req = operation_on_i;
      SRC_BOTH:      req = pin_on && operation_on_i;
      SRC_ALWAYS:    req = 1'b1;
      default:       req = pin_on;
    endcase
    req = req && st_r.pwr_q;
    st_nxt.req_q = req;
    req_rise = req && !st_r.req_q;
    clr = fault_clear_i || req_rise;

    nominal = vout_command_valid_i ? vout_command_i : strap.setpoint_mv;
    case (margin_t'(margin_select_i))
      MARGIN_HIGH: base = pick(margin_high_valid_i, margin_high_i, pct_of(nominal, `MARGIN_HI_PCT));
      MARGIN_LOW:  base = pick(margin_low_valid_i, margin_low_i, pct_of(nominal, `MARGIN_LO_PCT));
      default:     base = nominal;
    endcase
    trimmed = base + vout_trim_i;
    if (vout_trim_i[MV_W-1] && trimmed > base)
      trimmed = '0;
    vmax_dflt = pct_of(nominal, `VMAX_PCT);
    if (vmax_dflt > `VOUT_ABS_MAX_MV)
      vmax_dflt = `VOUT_ABS_MAX_MV;
    vmax = pick(vout_max_valid_i, vout_max_i, vmax_dflt);
    st_nxt.target = (trimmed > vmax) ? vmax : trimmed;
    st_nxt.track  = strap.track;

    ov_lim     = pick(ov_limit_valid_i, ov_limit_i, pct_of(nominal, `OV_PCT));
    uv_lim     = pick(uv_limit_valid_i, uv_limit_i, pct_of(nominal, `UV_PCT));
    pg_on_lim  = pick(pg_on_valid_i, pg_on_i, pct_of(nominal, `PG_ON_PCT));
    pg_off_lim = pick(pg_off_valid_i, pg_off_i, pct_of(nominal, `PG_OFF_PCT));

    // Voltage faults judged on the sensed level, not the enable, so a shutdown cannot hide its own cause; over-current only while enabled
    ov_now = vout_sense_i > ov_lim;
    uv_now = ramp_done_i && vout_sense_i < uv_lim;
    oc_now = st_r.en && ramp_done_i && iout_sense_i > oc_limit_i;

    ov_r = vresp(ov_now, ov_response_i, st_r.ov_lat, st_r.ov_dly, clr);
    uv_r = vresp(uv_now, uv_response_i, st_r.uv_lat, st_r.uv_dly, clr);
    st_nxt.ov_lat = ov_r[`DLY_CNT_W];
    st_nxt.ov_dly = ov_r[`DLY_CNT_W-1:0];
    st_nxt.uv_lat = uv_r[`DLY_CNT_W];
    st_nxt.uv_dly = uv_r[`DLY_CNT_W-1:0];

    ocr = ocresp_t'(oc_response_i);
    st_nxt.oc_remap = (ocr == OCRESP_DELAYED);
    if (ocr == OCRESP_DELAYED)
      ocr = OCRESP_HICCUP;
    oc_sd = 1'b0;
    case (ocr)
      OCRESP_CONTINUE: begin
        st_nxt.oc_lat  = 1'b0;
        st_nxt.hic_act = 1'b0;
        st_nxt.hic_cnt = '0;
      end
      OCRESP_LATCH: begin
        st_nxt.hic_act = 1'b0;
        st_nxt.hic_cnt = '0;
        if (clr)
          st_nxt.oc_lat = 1'b0;
        if (oc_now)
          st_nxt.oc_lat = 1'b1;
        oc_sd = st_nxt.oc_lat;
      end
      OCRESP_HICCUP: begin
        st_nxt.oc_lat = 1'b0;
        if (st_r.hic_act) begin
          if (st_r.hic_cnt == HIC_LAST) begin
            st_nxt.hic_act = 1'b0;
            st_nxt.hic_cnt = '0;
          end else begin
            st_nxt.hic_cnt = st_r.hic_cnt + 1'b1;
          end
        end else if (oc_now) begin
          st_nxt.hic_act = 1'b1;
          st_nxt.hic_cnt = '0;
        end
        oc_sd = st_nxt.hic_act;
      end
      default: begin
        st_nxt.oc_lat = 1'b0;
      end
    endcase

    fault_sd  = ov_r[`DLY_CNT_W+1] || uv_r[`DLY_CNT_W+1] || oc_sd;
    st_nxt.en = req && !fault_sd;
    st_nxt.ov_f = ov_now;
    st_nxt.uv_f = uv_now;
    st_nxt.oc_f = oc_now || st_nxt.oc_lat || st_nxt.hic_act;

    if (!st_nxt.en || fault_sd || ov_now || uv_now || oc_now || !ramp_done_i)
      st_nxt.pg = 1'b0;
    else if (!st_r.pg && vout_sense_i > pg_on_lim && calibration_done_i)
      st_nxt.pg = 1'b1;
    else if (st_r.pg && vout_sense_i < pg_off_lim)
      st_nxt.pg = 1'b0;
  end

  assign strap.res    = setpoint_strap_resistor_i;
  assign strap.sample = input_power_ok_i && !st_r.pwr_q;

  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      st_r <= '0;
    end else if (clk_en_i) begin
      st_r <= st_nxt;
    end
  end

  // Pin-edge outputs, all registered
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      output_enable_o        <= 1'b0;
      target_mv_o            <= '0;
      track_mode_o           <= 1'b0;
      power_good_output_o    <= 1'b0;
      power_good_output_oe_o <= 1'b1;
      over_voltage_fault_o   <= 1'b0;
      under_voltage_fault_o  <= 1'b0;
      over_current_fault_o   <= 1'b0;
      oc_response_remapped_o <= 1'b0;
    end else if (clk_en_i) begin
      output_enable_o        <= st_nxt.en;
      target_mv_o            <= st_nxt.target;
      track_mode_o           <= st_nxt.track;
      power_good_output_o    <= st_nxt.pg;
      power_good_output_oe_o <= !st_nxt.pg;
      over_voltage_fault_o   <= st_nxt.ov_f;
      under_voltage_fault_o  <= st_nxt.uv_f;
      over_current_fault_o   <= st_nxt.oc_f;
      oc_response_remapped_o <= st_nxt.oc_remap;
    end
  end

endmodule

//--- dv/pol_host_model.sv
`timescale 1ns/10ps
module pol_host_model (
  input  wire logic       sw_closed_i,
  input  wire logic [3:0] op_cfg_i,
  output logic            remote_on_off_o,
  output logic [1:0]      on_off_source_o,
  output logic            on_off_invert_o,
  output logic            operation_on_o
);
  // Open switch leaves the pin to its pull-up; no sync clock here to settle
  assign remote_on_off_o = !sw_closed_i;
  // Host settings: source, polarity, operation on bit
  assign {on_off_source_o, on_off_invert_o, operation_on_o} = op_cfg_i;
endmodule

//--- dv/output_enable_fault_supervisor_asserts.sv
`timescale 1ns/10ps
module output_enable_fault_supervisor_asserts (
  input wire logic       core_clk_i,
  input wire logic       reset_i,
  input wire logic       input_power_ok_i,
  input wire logic       remote_on_off_i,
  input wire logic [1:0] on_off_source_i,
  input wire logic       on_off_invert_i,
  input wire logic       ramp_done_i,
  input wire logic       calibration_done_i,
  input wire logic [1:0] ov_response_i,
  input wire logic [1:0] oc_response_i,
  input wire logic       output_enable_o,
  input wire logic       track_mode_o,
  input wire logic       power_good_output_o,
  input wire logic       power_good_output_oe_o,
  input wire logic       over_voltage_fault_o,
  input wire logic       under_voltage_fault_o,
  input wire logic       over_current_fault_o,
  input wire logic       oc_response_remapped_o
);
  typedef struct packed {
    logic       pwr;
    logic [2:0] age;
  } rise_st_t;
  rise_st_t st_r;
  rise_st_t st_nxt;
  wire      any_fault = over_voltage_fault_o || under_voltage_fault_o || over_current_fault_o;
  // Cycles since the last power rise, saturating
  always_comb begin
    st_nxt     = st_r;
    st_nxt.pwr = input_power_ok_i;
    if (input_power_ok_i && !st_r.pwr) begin
      st_nxt.age = 3'h0;
    end else if (st_r.age != 3'h7) begin
      st_nxt.age = st_r.age + 3'h1;
    end
  end
  always_ff @(posedge core_clk_i or posedge reset_i) begin
    if (reset_i) begin
      st_r <= 4'h7;
    end else begin
      st_r <= st_nxt;
    end
  end
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (reset_i);
  sequence ov_hit;
    $rose(over_voltage_fault_o) && (ov_response_i == 2'h3);
  endsequence
  sequence hiccup_start;
    $rose(over_current_fault_o) && oc_response_i[1];
  endsequence
  chk_pg_oe_inverse: assert property (power_good_output_oe_o == !power_good_output_o)
    else $error("power-good drive not inverse of level");
  chk_pg_fault_low: assert property (any_fault && $past(any_fault) |-> !power_good_output_o)
    else $error("power-good high during fault");
  chk_pg_ramp_low: assert property (!ramp_done_i |=> !power_good_output_o)
    else $error("power-good high before ramp done");
  chk_pg_rise_cond: assert property (
    $rose(power_good_output_o) |-> $past(calibration_done_i) && $past(ramp_done_i))
    else $error("power-good rose without calibration");
  chk_oc_after_ramp: assert property ($rose(over_current_fault_o) |-> $past(ramp_done_i))
    else $error("over-current seen during ramp");
  chk_oc_remap_flag: assert property (
    1'b1 |=> oc_response_remapped_o == ($past(oc_response_i) == 2'h3))
    else $error("remap flag wrong");
  chk_hiccup_off: assert property (
    hiccup_start |-> ##1 (!output_enable_o && !power_good_output_o) [*8])
    else $error("output or power-good on during restart wait");
  chk_ov_shut_now: assert property (ov_hit |-> !output_enable_o)
    else $error("output on with over-voltage present");
  chk_pin_off: assert property (
    (on_off_source_i == 2'h0) && (remote_on_off_i == on_off_invert_i) |=> !output_enable_o)
    else $error("output on while pin requests off");
  chk_strap_hold: assert property ($changed(track_mode_o) |-> st_r.age <= 3'h3)
    else $error("strap mode changed without power rise");
endmodule

bind output_enable_fault_supervisor output_enable_fault_supervisor_asserts
  i_output_enable_fault_supervisor_asserts (.*);

//--- dv/test_output_enable_fault_supervisor.sv
`timescale 1ns/10ps
module test_output_enable_fault_supervisor;
  logic core_clk_i, reset_i, clk_en_i, input_power_ok_i, remote_on_off_i, on_off_invert_i, operation_on_i;
  logic vout_command_valid_i, margin_high_valid_i, margin_low_valid_i, vout_max_valid_i, ov_limit_valid_i;
  logic uv_limit_valid_i, pg_on_valid_i, pg_off_valid_i, ramp_done_i, calibration_done_i, fault_clear_i, sw;
  logic output_enable_o, track_mode_o, power_good_output_o, power_good_output_oe_o, over_voltage_fault_o;
  logic under_voltage_fault_o, over_current_fault_o, oc_response_remapped_o, pgs;
  logic [1:0] on_off_source_i, margin_select_i, ov_response_i, uv_response_i, oc_response_i;
  logic [3:0] cfg;
  logic [15:0] setpoint_strap_resistor_i, vout_command_i, vout_trim_i, margin_high_i, margin_low_i, vout_max_i;
  logic [15:0] ov_limit_i, uv_limit_i, pg_on_i, pg_off_i, oc_limit_i, vout_sense_i, iout_sense_i, target_mv_o;
  int failures, cmp_count, ovl, uvl, onl, offl, vs;
  int strap_res[16] = '{511, 619, 715, 825, 953, 1100, 1270, 1470, 1780, 2150, 2610, 3160, 3830, 4420, 5110, 5900};
  int strap_mv[16] = '{600, 700, 750, 800, 850, 900, 950, 1000, 1050, 1100, 1200, 1500, 1800, 2500, 3300, 5000};
  int vlist[13] = '{1200, 1100, 1195, 1170, 1155, 1140, 1260, 1200, 1081, 1000, 1400, 1380, 1200};

  output_enable_fault_supervisor #(.HICCUP_CYC(20)) i_output_enable_fault_supervisor (.*);
  pol_host_model i_pol_host_model (
    .sw_closed_i     (sw),
    .op_cfg_i        (cfg),
    .remote_on_off_o (remote_on_off_i),
    .on_off_source_o (on_off_source_i),
    .on_off_invert_o (on_off_invert_i),
    .operation_on_o  (operation_on_i)
  );

  initial begin
    core_clk_i = 1'b0;
    forever #50 core_clk_i = ~core_clk_i;
  end

  task automatic step(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic power_cycle(input int r);
    input_power_ok_i = 1'b0;
    step(1);
    setpoint_strap_resistor_i = 16'(r);
    input_power_ok_i = 1'b1;
    step(4);
  endtask
  task automatic pulse_clear();
    fault_clear_i = 1'b1;
    step(1);
    fault_clear_i = 1'b0;
    step(3);
  endtask
  function automatic logic exp_en(input logic [3:0] c, input logic s);
    logic pin;
    pin = !s ^ c[1];
    case (c[3:2])
      2'h0: return pin;
      2'h1: return c[0];
      2'h2: return pin & c[0];
      default: return 1'b1;
    endcase
  endfunction
  function automatic logic [15:0] exp_tgt();
    int n, b, lim;
    n = vout_command_i;
    b = n;
    if (margin_select_i == 2'h2) b = margin_high_valid_i ? int'(margin_high_i) : n * 105 / 100;
    if (margin_select_i == 2'h1) b = margin_low_valid_i ? int'(margin_low_i) : n * 95 / 100;
    b = b + $signed(vout_trim_i);
    lim = vout_max_valid_i ? int'(vout_max_i) : (n * 110 / 100 < 5500 ? n * 110 / 100 : 5500);
    if (b < 0) b = 0;
    return 16'(b > lim ? lim : b);
  endfunction

  initial begin
    #1000000;
    failures++;
    end_of_test();
  end

  initial begin
    void'($urandom(32'hd0a0));
    {reset_i, clk_en_i, input_power_ok_i, sw, cfg, margin_select_i} = 10'h300;
    {vout_command_valid_i, margin_high_valid_i, margin_low_valid_i, vout_max_valid_i} = 4'h0;
    {ov_limit_valid_i, uv_limit_valid_i, pg_on_valid_i, pg_off_valid_i} = 4'h0;
    {ramp_done_i, calibration_done_i, fault_clear_i} = 3'h0;
    {ov_response_i, uv_response_i, oc_response_i} = 6'h3e;
    {setpoint_strap_resistor_i, vout_command_i, vout_trim_i, margin_high_i, margin_low_i, vout_max_i} = '0;
    {ov_limit_i, uv_limit_i, pg_on_i, pg_off_i, oc_limit_i, vout_sense_i, iout_sense_i} = '0;
    step(5);
    chk("pg_oe", 1'b1, power_good_output_oe_o);
    chk("pg", 1'b0, power_good_output_o);
    reset_i = 1'b0;
    // Strap decode across all bands, open and the tracking boundary
    for (int i = 0; i < 18; i++) begin
      vs = i < 16 ? strap_res[i] : (i == 16 ? 65535 : 422);
      if (i < 16) vs = vs - vs / 100 + $urandom_range(vs / 50);
      power_cycle(vs);
      chk("target", i < 16 ? 16'(strap_mv[i]) : 16'h0, target_mv_o);
      chk("track", i == 17, track_mode_o);
    end
    power_cycle(2610);
    setpoint_strap_resistor_i = 16'd5900;
    step(6);
    chk("target", 16'd1200, target_mv_o);
    vout_sense_i = 16'd1200;
    for (int i = 0; i < 40; i++) begin
      cfg = {2'(i), 2'($urandom)};
      sw = 1'($urandom);
      step(3);
      chk("enable", exp_en(cfg, sw), output_enable_o);
    end
    vout_command_valid_i = 1'b1;
    for (int i = 0; i < 40; i++) begin
      vout_command_i = 16'($urandom_range(6000, 500));
      vout_trim_i = i == 0 ? 16'hfc00 : 16'($urandom_range(600) - 300);
      margin_select_i = 2'(i);
      {margin_high_valid_i, margin_low_valid_i, vout_max_valid_i} = 3'($urandom);
      margin_high_i = 16'($urandom_range(6000, 400));
      margin_low_i = 16'($urandom_range(6000, 400));
      vout_max_i = 16'($urandom_range(6000, 400));
      step(3);
      chk("target", exp_tgt(), target_mv_o);
    end
    {vout_command_valid_i, margin_select_i, vout_trim_i} = '0;
    // Thresholds, default then overridden, with faults ignored
    {cfg, ov_response_i, uv_response_i} = 8'hc0;
    {ov_limit_i, uv_limit_i, pg_on_i, pg_off_i} = {16'd1250, 16'd1150, 16'd1190, 16'd1160};
    for (int o = 0; o < 2; o++) begin
      {ov_limit_valid_i, uv_limit_valid_i, pg_on_valid_i, pg_off_valid_i} = {4{1'(o)}};
      {ovl, uvl, onl, offl} = o ? {32'd1250, 32'd1150, 32'd1190, 32'd1160} : {32'd1380, 32'd1020, 32'd1080, 32'd1020};
      {ramp_done_i, pgs} = 2'h0;
      step(2);
      ramp_done_i = 1'b1;
      foreach (vlist[j]) begin
        vs = vlist[j];
        vout_sense_i = 16'(vs);
        calibration_done_i = j > 0;
        step(4);
        if (vs > ovl || vs < uvl) pgs = 1'b0;
        else if (vs > onl && j > 0) pgs = 1'b1;
        else if (vs < offl) pgs = 1'b0;
        chk("ov", vs > ovl, over_voltage_fault_o);
        chk("uv", vs < uvl, under_voltage_fault_o);
        chk("pg", pgs, power_good_output_o);
      end
    end
    {ov_limit_valid_i, uv_limit_valid_i, pg_on_valid_i, pg_off_valid_i} = 4'h0;
    // Each voltage response, over-voltage then under-voltage
    for (int k = 0; k < 8; k++) begin
      {ov_response_i, uv_response_i} = {2'(k), 2'(k)};
      vout_sense_i = k < 4 ? 16'd1400 : 16'd1000;
      step(3);
      chk("enable", k[1:0] < 2'h2, output_enable_o);
      step(100);
      chk("enable", k[1:0] == 2'h0, output_enable_o);
      vout_sense_i = 16'd1200;
      step(3);
      chk("enable", k[1:0] == 2'h0 || k[1:0] == 2'h3, output_enable_o);
      pulse_clear();
      chk("enable", 1'b1, output_enable_o);
    end
    {ramp_done_i, oc_limit_i, iout_sense_i} = {1'b0, 16'd1000, 16'd1500};
    step(3);
    chk("oc_fault", 1'b0, over_current_fault_o);
    for (int r = 0; r < 4; r++) begin
      oc_response_i = 2'(r);
      oc_limit_i = 16'($urandom_range(3000, 1000));
      iout_sense_i = oc_limit_i + 16'h1;
      ramp_done_i = 1'b1;
      step(3);
      chk("oc_fault", 1'b1, over_current_fault_o);
      chk("enable", r == 0, output_enable_o);
      chk("remapped", r == 3, oc_response_remapped_o);
      iout_sense_i = oc_limit_i;
      step(17);
      chk("enable", r == 0, output_enable_o);
      step(1);
      chk("enable", r != 1, output_enable_o);
      pulse_clear();
      chk("enable", 1'b1, output_enable_o);
      ramp_done_i = 1'b0;
      step(2);
    end
    end_of_test();
  end
endmodule
